// file: tmr2_pkg.sv
`default_nettype none
package tmr2_pkg;
  // word indices on the APB slave, byte address is four times idx; sfr offsets kept as indices
  localparam logic [7:0] TMR2_IDX_CONTROL = 8'hC8;
  localparam logic [7:0] TMR2_IDX_MODE = 8'hC9;
  localparam logic [7:0] TMR2_IDX_CAP_LOW = 8'hCA;
  localparam logic [7:0] TMR2_IDX_CAP_HIGH = 8'hCB;
  localparam logic [7:0] TMR2_IDX_CNT_LOW = 8'hCC;
  localparam logic [7:0] TMR2_IDX_CNT_HIGH = 8'hCD;
  localparam logic [7:0] TMR2_IDX_IRQ_STATUS = 8'hCE;
  localparam logic [7:0] TMR2_IDX_IRQ_MASK = 8'hCF;
  // control register field positions
  localparam int TMR2_BIT_OVF = 7;
  localparam int TMR2_BIT_EXT = 6;
  localparam int TMR2_BIT_RXSEL = 5;
  localparam int TMR2_BIT_TXSEL = 4;
  localparam int TMR2_BIT_TRIGEN = 3;
  localparam int TMR2_BIT_RUN = 2;
  localparam int TMR2_BIT_SRC = 1;
  localparam int TMR2_BIT_CAPSEL = 0;
  // mode register field
  localparam int TMR2_BIT_UPDOWN = 0;
  // irq status field positions
  localparam int TMR2_IRQ_OVF = 0;
  localparam int TMR2_IRQ_EXT = 1;
  localparam int TMR2_IRQ_CAPTURE = 2;
  // reset values
  localparam logic [7:0] TMR2_RST_CONTROL = 8'h00;
  localparam logic [7:0] TMR2_RST_MODE = 8'h00;
  localparam logic [7:0] TMR2_RST_BYTE = 8'h00;
  localparam logic [2:0] TMR2_RST_IRQ = 3'h0;
  // timer mode counts one per machine cycle of 12 clocks
  localparam logic [3:0] TMR2_PRESCALE_LAST = 4'hB;
  localparam logic [15:0] TMR2_CNT_MAX = 16'hFFFF;
endpackage : tmr2_pkg
`default_nettype wire

// file: tmr2_ctrl.sv
// Implementation choice: the APB slave port.
`default_nettype none
// What this block does
// RQ1: overflow sets control bit 7, not while either baud select is set
// RQ2: trigger falling edge with trigger enable sets control bit 6, not while either baud select is set
// RQ3: bit 6 raises the interrupt unless up/down mode is on
// RQ4: receive baud select bit 5 routes timer 2 or timer 1 overflow
// RQ5: transmit baud select bit 4 routes timer 2 or timer 1 overflow
// RQ6: trigger enable bit 3 gates trigger edges unless baud clocking
// RQ7: run control bit 2 starts and stops counting
// RQ8: source select bit 1 picks timer or falling edges of count pin
// RQ9: capture select bit 0 with trigger enable captures on trigger edges
// RQ10: reload mode reloads on overflow and on enabled trigger edges
// RQ11: baud clocking forces auto-reload, capture select ignored
// RQ12: capture pair holds captured value or reload value
// RQ13: control register at 0C8H, bit addressable, resets to zero
// RQ14: count pin is external count input, trigger pin triggers captures
// RQ15: capture copies counter to pair, reload copies pair to counter
module tmr2_ctrl
  import tmr2_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic count_input_pin,
  input wire logic trigger_pin,
  input wire logic timer1_overflow,
  input wire logic [1:0] serial_mode,
  output logic rx_baud_tick,
  output logic tx_baud_tick,
  output logic timer2_irq,
  output logic irq
);

  // ----------------------------------------
  // register state
  // ----------------------------------------
  logic [7:0] control_register;
  logic [7:0] mode_register;
  logic [7:0] capture_reg_low;
  logic [7:0] capture_reg_high;
  logic [7:0] counter_low;
  logic [7:0] counter_high;
  logic [2:0] irq_status;
  logic [2:0] irq_mask;
  logic [3:0] prescale;
  logic count_pin_q;
  logic trigger_pin_q;

  function automatic logic is_reg(input logic [31:0] a,
                                  input logic [7:0] idx);
    is_reg = (a == {22'h0, idx, 2'h0});
  endfunction : is_reg

  logic wr_access;
  logic rd_setup;
  logic mapped;
  assign wr_access = psel && penable && pwrite;
  assign rd_setup = psel && !penable && !pwrite;
  assign mapped = paddr[31:10] == 22'h0 && paddr[1:0] == 2'h0 &&
    paddr[9:2] >= TMR2_IDX_CONTROL && paddr[9:2] <= TMR2_IDX_IRQ_MASK;

  // ----------------------------------------
  // counting and events
  // ----------------------------------------
  logic baud_mode;
  logic run;
  logic prescale_tick;
  logic count_edge;
  logic count_step;
  logic [15:0] counter;
  logic [15:0] capture_pair;
  logic overflow;
  logic trig_edge;
  logic capture_ev;
  logic reload_ev;
  logic wr_cnt;

  assign baud_mode = control_register[TMR2_BIT_RXSEL] |
                     control_register[TMR2_BIT_TXSEL];
  assign run = control_register[TMR2_BIT_RUN]; // RQ7
  assign prescale_tick = prescale == TMR2_PRESCALE_LAST;
  assign count_edge = count_pin_q && !count_input_pin; // RQ14
  assign count_step = run && (control_register[TMR2_BIT_SRC] ?
                      count_edge : prescale_tick); // RQ8
  assign counter = {counter_high, counter_low};
  assign capture_pair = {capture_reg_high, capture_reg_low}; // RQ12
  assign overflow = count_step && counter == TMR2_CNT_MAX;
  assign trig_edge = trigger_pin_q && !trigger_pin &&
                     control_register[TMR2_BIT_TRIGEN] &&
                     !baud_mode; // RQ6 RQ14
  assign capture_ev = trig_edge &&
                      control_register[TMR2_BIT_CAPSEL]; // RQ9 RQ11
  assign reload_ev = (overflow && (baud_mode ||
                      !control_register[TMR2_BIT_CAPSEL])) ||
                     (trig_edge &&
                      !control_register[TMR2_BIT_CAPSEL]); // RQ10 RQ11
  assign wr_cnt = wr_access && (is_reg(paddr, TMR2_IDX_CNT_LOW) ||
                                is_reg(paddr, TMR2_IDX_CNT_HIGH));

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prescale <= 4'h0;
    end else if (prescale_tick) begin
      prescale <= 4'h0;
    end else begin
      prescale <= prescale + 4'h1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count_pin_q <= 1'b1;
      trigger_pin_q <= 1'b1;
    end else begin
      count_pin_q <= count_input_pin;
      trigger_pin_q <= trigger_pin;
    end
  end

  // software write to a counter byte beats a same-cycle count step
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      counter_low <= TMR2_RST_BYTE;
      counter_high <= TMR2_RST_BYTE;
    end else if (wr_cnt) begin
      if (is_reg(paddr, TMR2_IDX_CNT_LOW)) begin
        counter_low <= pwdata[7:0];
      end else begin
        counter_high <= pwdata[7:0];
      end
    end else if (reload_ev) begin
      {counter_high, counter_low} <= capture_pair; // RQ15
    end else if (count_step) begin
      {counter_high, counter_low} <= counter + 16'h0001;
    end
  end

  // capture wins over a software write to the pair in the same cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      capture_reg_low <= TMR2_RST_BYTE;
      capture_reg_high <= TMR2_RST_BYTE;
    end else if (capture_ev) begin
      {capture_reg_high, capture_reg_low} <= counter; // RQ15
    end else if (wr_access && is_reg(paddr, TMR2_IDX_CAP_LOW)) begin
      capture_reg_low <= pwdata[7:0];
    end else if (wr_access && is_reg(paddr, TMR2_IDX_CAP_HIGH)) begin
      capture_reg_high <= pwdata[7:0];
    end
  end

  // ----------------------------------------
  // control and mode registers
  // ----------------------------------------
  logic set_ovf;
  logic set_ext;
  assign set_ovf = overflow && !baud_mode; // RQ1
  assign set_ext = trig_edge; // RQ2

  // flags: hardware set wins over a software clear in the same cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      control_register <= TMR2_RST_CONTROL; // RQ13
    end else begin
      if (wr_access && is_reg(paddr, TMR2_IDX_CONTROL)) begin
        control_register <= pwdata[7:0];
      end
      if (set_ovf) begin
        control_register[TMR2_BIT_OVF] <= 1'b1; // RQ1
      end
      if (set_ext) begin
        control_register[TMR2_BIT_EXT] <= 1'b1; // RQ2
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_register <= TMR2_RST_MODE;
    end else if (wr_access && is_reg(paddr, TMR2_IDX_MODE)) begin
      mode_register <= {7'h00, pwdata[TMR2_BIT_UPDOWN]};
    end
  end

  // ----------------------------------------
  // baud routing and interrupts
  // ----------------------------------------
  logic uart_variable;
  assign uart_variable = serial_mode[0]; // modes 1 and 3

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_baud_tick <= 1'b0;
      tx_baud_tick <= 1'b0;
    end else begin
      rx_baud_tick <= uart_variable &&
        (control_register[TMR2_BIT_RXSEL] ? overflow :
         timer1_overflow); // RQ4
      tx_baud_tick <= uart_variable &&
        (control_register[TMR2_BIT_TXSEL] ? overflow :
         timer1_overflow); // RQ5
    end
  end

  // cpu-side request; the enable bit lives in the cpu's own enable reg
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      timer2_irq <= 1'b0;
    end else begin
      timer2_irq <= control_register[TMR2_BIT_OVF] ||
        (control_register[TMR2_BIT_EXT] &&
         !mode_register[TMR2_BIT_UPDOWN]); // RQ3
    end
  end

  logic [2:0] irq_events;
  assign irq_events = {capture_ev, set_ext, set_ovf};

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_status <= TMR2_RST_IRQ;
    end else if (wr_access && is_reg(paddr, TMR2_IDX_IRQ_STATUS)) begin
      irq_status <= (irq_status & ~pwdata[2:0]) | irq_events;
    end else begin
      irq_status <= irq_status | irq_events;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_mask <= TMR2_RST_IRQ;
    end else if (wr_access && is_reg(paddr, TMR2_IDX_IRQ_MASK)) begin
      irq_mask <= pwdata[2:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq <= 1'b0;
    end else begin
      irq <= |(irq_status & irq_mask);
    end
  end

  // ----------------------------------------
  // apb read path: data latched in setup, answer with no wait
  // ----------------------------------------
  logic [7:0] rd_byte;
  always_comb begin
    rd_byte = 8'h00;
    case (paddr[9:2])
      TMR2_IDX_CONTROL: rd_byte = control_register;
      TMR2_IDX_MODE: rd_byte = mode_register;
      TMR2_IDX_CAP_LOW: rd_byte = capture_reg_low;
      TMR2_IDX_CAP_HIGH: rd_byte = capture_reg_high;
      TMR2_IDX_CNT_LOW: rd_byte = counter_low;
      TMR2_IDX_CNT_HIGH: rd_byte = counter_high;
      TMR2_IDX_IRQ_STATUS: rd_byte = {5'h00, irq_status};
      TMR2_IDX_IRQ_MASK: rd_byte = {5'h00, irq_mask};
      default: rd_byte = 8'h00;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= psel && !penable;
      pslverr <= psel && !penable && !mapped;
      if (rd_setup) begin
        prdata <= mapped ? {24'h000000, rd_byte} : 32'h0000_0000;
      end
    end
  end

  // ----------------------------------------
  // checks
  // ----------------------------------------
  property p_ovf_set;
    @(posedge pclk) disable iff (!presetn)
    set_ovf |=> control_register[TMR2_BIT_OVF];
  endproperty
  a_ovf_set: assert property (p_ovf_set) else $error("ovf flag missed"); // RQ1

  property p_ovf_baud;
    @(posedge pclk) disable iff (!presetn)
    (baud_mode && !control_register[TMR2_BIT_OVF] &&
     !wr_access) |=> !control_register[TMR2_BIT_OVF];
  endproperty
  a_ovf_baud: assert property (p_ovf_baud) else $error("ovf in baud"); // RQ1

  property p_ext_set;
    @(posedge pclk) disable iff (!presetn)
    trig_edge |=> control_register[TMR2_BIT_EXT];
  endproperty
  a_ext_set: assert property (p_ext_set) else $error("ext flag missed"); // RQ2

  property p_updown_quiet;
    @(posedge pclk) disable iff (!presetn)
    (mode_register[TMR2_BIT_UPDOWN] &&
     !control_register[TMR2_BIT_OVF]) |=> !timer2_irq;
  endproperty
  a_updown_quiet: assert property (p_updown_quiet) else $error("irq in updown"); // RQ3

  property p_rx_route;
    @(posedge pclk) disable iff (!presetn)
    (uart_variable && control_register[TMR2_BIT_RXSEL] && overflow)
      |=> rx_baud_tick;
  endproperty
  a_rx_route: assert property (p_rx_route) else $error("rx tick missed"); // RQ4

  property p_tx_route;
    @(posedge pclk) disable iff (!presetn)
    (uart_variable && !control_register[TMR2_BIT_TXSEL] &&
     timer1_overflow) |=> tx_baud_tick;
  endproperty
  a_tx_route: assert property (p_tx_route) else $error("tx tick missed"); // RQ5

  property p_stopped;
    @(posedge pclk) disable iff (!presetn)
    (!run && !wr_cnt && !reload_ev) |=> $stable(counter);
  endproperty
  a_stopped: assert property (p_stopped) else $error("counter moved"); // RQ7

  property p_capture;
    @(posedge pclk) disable iff (!presetn)
    capture_ev |=> capture_pair == $past(counter);
  endproperty
  a_capture: assert property (p_capture) else $error("capture wrong"); // RQ9

  property p_reload;
    @(posedge pclk) disable iff (!presetn)
    (overflow && baud_mode && !wr_cnt) |=> counter == $past(capture_pair);
  endproperty
  a_reload: assert property (p_reload) else $error("reload wrong"); // RQ11

  // ----------------------------------------
  // checks on the answer, counting and interrupt
  // ----------------------------------------
  sequence s_setup;
    psel && !penable;
  endsequence

  sequence s_answer;
    pready ##1 !pready;
  endsequence

  property p_apb_answer;
    @(posedge pclk) disable iff (!presetn)
    s_setup |=> s_answer;
  endproperty
  a_apb_answer: assert property (p_apb_answer) else $error("no answer");

  property p_count_step;
    @(posedge pclk) disable iff (!presetn)
    (count_step && !wr_cnt && !reload_ev) |=>
      counter == $past(counter) + 16'h0001;
  endproperty
  a_count_step: assert property (p_count_step) // RQ8
    else $error("count step missed");

  property p_trig_reload;
    @(posedge pclk) disable iff (!presetn)
    (reload_ev && !wr_cnt) |=> counter == $past(capture_pair);
  endproperty
  a_trig_reload: assert property (p_trig_reload) // RQ10
    else $error("reload missed");

  property p_ext_irq;
    @(posedge pclk) disable iff (!presetn)
    (control_register[TMR2_BIT_EXT] &&
     !mode_register[TMR2_BIT_UPDOWN]) |=> timer2_irq;
  endproperty
  a_ext_irq: assert property (p_ext_irq) // RQ3
    else $error("ext irq missed");

  property p_irq_level;
    @(posedge pclk) disable iff (!presetn)
    (|(irq_status & irq_mask)) |=> irq;
  endproperty
  a_irq_level: assert property (p_irq_level) else $error("irq missed");

endmodule : tmr2_ctrl
`default_nettype wire

// file: tmr2_pins.sv
`default_nettype none
module tmr2_pins (
  input wire logic pclk,
  output logic count_input_pin,
  output logic trigger_pin,
  output logic timer1_overflow
);
  timeunit 1ns;
  timeprecision 1ns;
  // port pins are pulled up, so they rest high between events
  initial begin
    count_input_pin = 1'b1;
    trigger_pin = 1'b1;
    timer1_overflow = 1'b0;
  end
  // each level is held two cycles so the sampler cannot miss it
  task automatic fall(input logic trig);
    if (trig) begin
      trigger_pin <= 1'b0;
    end else begin
      count_input_pin <= 1'b0;
    end
    repeat (2) @(posedge pclk);
    trigger_pin <= 1'b1;
    count_input_pin <= 1'b1;
    repeat (2) @(posedge pclk);
  endtask : fall
  task automatic t1_pulse();
    timer1_overflow <= 1'b1;
    @(posedge pclk);
    timer1_overflow <= 1'b0;
    repeat (2) @(posedge pclk);
  endtask : t1_pulse
endmodule : tmr2_pins
`default_nettype wire

// file: timer2_control_logic_tb_top.sv
`default_nettype none
module timer2_control_logic_tb_top
  import tmr2_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic pclk;
  logic presetn;
  logic psel;
  logic penable;
  logic pwrite;
  logic [31:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic pready, pslverr, cnt_pin, trg_pin, t1_ovf, rx_tick, tx_tick;
  logic t2_irq, irq;
  logic [1:0] serial_mode;
  logic [7:0] rdat;
  logic rerr;
  int num_errors = 0;
  int n_compared = 0;
  int cyc = 0;
  int rx_n = 0;
  int tx_n = 0;
  always #10 pclk = ~pclk;
  tmr2_ctrl dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .count_input_pin(cnt_pin), .trigger_pin(trg_pin),
    .timer1_overflow(t1_ovf), .serial_mode(serial_mode),
    .rx_baud_tick(rx_tick), .tx_baud_tick(tx_tick),
    .timer2_irq(t2_irq), .irq(irq));
  tmr2_pins pins (.pclk(pclk), .count_input_pin(cnt_pin),
    .trigger_pin(trg_pin), .timer1_overflow(t1_ovf));
  always @(posedge pclk) begin
    rx_n <= rx_n + (rx_tick === 1'b1 ? 1 : 0);
    tx_n <= tx_n + (tx_tick === 1'b1 ? 1 : 0);
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      num_errors++;
      test_done();
    end
  end
  task automatic test_done();
    if (num_errors == 0 && n_compared > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : test_done
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp) begin
      num_errors++;
      $display("ERROR at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask : chk
  // ---------------------------------------------------------------
  // apb master: one word per register, byte address is four times idx
  // ---------------------------------------------------------------
  task automatic xfer(input logic w, input logic [7:0] idx,
                      input logic [7:0] d);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= {22'h0, idx, 2'b00};
    pwdata <= {24'h0, d};
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rdat = prdata[7:0];
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : xfer
  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    xfer(1'b1, idx, d);
  endtask : wr
  task automatic rd(input logic [7:0] idx, input logic [7:0] exp);
    xfer(1'b0, idx, 8'h00);
    chk(rdat, exp);
  endtask : rd
  task automatic set_cnt(input logic [7:0] lo, input logic [7:0] hi);
    wr(TMR2_IDX_CNT_LOW, lo);
    wr(TMR2_IDX_CNT_HIGH, hi);
  endtask : set_cnt
  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  task automatic sc_reset();
    rd(TMR2_IDX_CONTROL, 8'h00);
    rd(TMR2_IDX_CAP_HIGH, 8'h00);
    rd(TMR2_IDX_CNT_LOW, 8'h00);
    rd(8'hD0, 8'h00);
    chk({7'h0, rerr}, 8'h01);
  endtask : sc_reset
  task automatic sc_capture();
    set_cnt(8'h34, 8'h12);
    wr(TMR2_IDX_CONTROL, 8'h0F);
    repeat (3) pins.fall(1'b0);
    rd(TMR2_IDX_CNT_LOW, 8'h37);
    pins.fall(1'b1);
    rd(TMR2_IDX_CAP_LOW, 8'h37);
    rd(TMR2_IDX_CAP_HIGH, 8'h12);
    rd(TMR2_IDX_CONTROL, 8'h4F);
    rd(TMR2_IDX_IRQ_STATUS, 8'h06);
    chk({7'h0, t2_irq}, 8'h01);
    wr(TMR2_IDX_IRQ_MASK, 8'h02);
    // irq and timer2_irq are registered: let the launching edge pass
    @(posedge pclk);
    chk({7'h0, irq}, 8'h01);
    wr(TMR2_IDX_MODE, 8'h01);
    @(posedge pclk);
    chk({7'h0, t2_irq}, 8'h00);
    wr(TMR2_IDX_IRQ_STATUS, 8'h02);
    @(posedge pclk);
    chk({7'h0, irq}, 8'h00);
    wr(TMR2_IDX_MODE, 8'h00);
    wr(TMR2_IDX_CONTROL, 8'h07);
    pins.fall(1'b1);
    rd(TMR2_IDX_CONTROL, 8'h07);
    rd(TMR2_IDX_CAP_LOW, 8'h37);
  endtask : sc_capture
  task automatic sc_reload();
    wr(TMR2_IDX_CONTROL, 8'h06);
    wr(TMR2_IDX_CAP_LOW, 8'h00);
    wr(TMR2_IDX_CAP_HIGH, 8'h50);
    set_cnt(8'hFE, 8'hFF);
    repeat (2) pins.fall(1'b0);
    rd(TMR2_IDX_CNT_HIGH, 8'h50);
    rd(TMR2_IDX_CNT_LOW, 8'h00);
    rd(TMR2_IDX_CONTROL, 8'h86);
    wr(TMR2_IDX_CONTROL, 8'h0E);
    pins.fall(1'b0);
    pins.fall(1'b1);
    rd(TMR2_IDX_CNT_LOW, 8'h00);
    rd(TMR2_IDX_CONTROL, 8'h4E);
    pins.t1_pulse();
    chk(8'(rx_n), 8'h01);
    chk(8'(tx_n), 8'h01);
  endtask : sc_reload
  task automatic sc_baud();
    serial_mode <= 2'h1;
    wr(TMR2_IDX_CONTROL, 8'h3F);
    wr(TMR2_IDX_CAP_LOW, 8'h34);
    wr(TMR2_IDX_CAP_HIGH, 8'h12);
    set_cnt(8'hFF, 8'hFF);
    pins.fall(1'b0);
    rd(TMR2_IDX_CNT_HIGH, 8'h12);
    rd(TMR2_IDX_CONTROL, 8'h3F);
    chk(8'(rx_n), 8'h02);
    chk(8'(tx_n), 8'h02);
    pins.fall(1'b1);
    rd(TMR2_IDX_CAP_LOW, 8'h34);
    rd(TMR2_IDX_CONTROL, 8'h3F);
    pins.t1_pulse();
    chk(8'(rx_n), 8'h02);
    wr(TMR2_IDX_CONTROL, 8'h02);
    pins.fall(1'b0);
    rd(TMR2_IDX_CNT_LOW, 8'h34);
    // timer mode: 120 running edges between the two control writes
    // hold exactly ten machine cycles whatever the prescaler phase
    set_cnt(8'h00, 8'h00);
    wr(TMR2_IDX_CONTROL, 8'h04);
    repeat (117) @(posedge pclk);
    wr(TMR2_IDX_CONTROL, 8'h00);
    rd(TMR2_IDX_CNT_LOW, 8'h0A);
  endtask : sc_baud
  initial begin
    pclk = 1'b0;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 32'h0;
    pwdata = 32'h0;
    serial_mode = 2'h3;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    sc_reset();
    sc_capture();
    sc_reload();
    sc_baud();
    test_done();
  end
endmodule : timer2_control_logic_tb_top
`default_nettype wire
